// ---- ucta_pkg.sv ----
// Package of constants and types for the user circuit test access block
package ucta_pkg;
  localparam int            UCTA_ADDR_W        = 18;
  localparam int            UCTA_DATA_W        = 16;
  localparam int            UCTA_NUM_UCLK      = 5;
  localparam int            UCTA_SETTLE_CYCLES = 4;
  localparam int            UCTA_DCT_EDGES     = 4;
  localparam int            UCTA_USER_EDGES    = 1;
  localparam int            UCTA_CNT_W         = 3;
  localparam logic [2:0]    UCTA_SETTLE_CNT    = 3'(UCTA_SETTLE_CYCLES);
  localparam logic [2:0]    UCTA_DCT_CNT       = 3'(UCTA_DCT_EDGES);
  localparam logic [2:0]    UCTA_USER_CNT      = 3'(UCTA_USER_EDGES);
  localparam logic [2:0]    UCTA_CNT_ZERO      = 3'h0;
  localparam logic [2:0]    UCTA_CNT_ONE       = 3'h1;
  localparam logic          UCTA_DIR_READ      = 1'b1;

  typedef enum logic [4:0] {
    UCTA_ST_NORMAL = 5'h01,
    UCTA_ST_SETTLE = 5'h02,
    UCTA_ST_ARMED  = 5'h04,
    UCTA_ST_USER   = 5'h08,
    UCTA_ST_DCT    = 5'h10
  } ucta_state_t;
endpackage : ucta_pkg

// ---- ucta_sync_if.sv ----
// Interface carrying synchronised pad levels between the synchroniser and the top
`timescale 1ns/1ps
`default_nettype none
interface ucta_sync_if;
  logic [3:0] raw;
  logic [3:0] level;
  logic [3:0] rise;
  modport sync (input raw, output level, output rise);
  modport user (output raw, input level, input rise);
endinterface : ucta_sync_if
`default_nettype wire

// ---- ucta_sync.sv ----
// Three-flop pad synchroniser with agreement check and rise detect
`timescale 1ns/1ps
`default_nettype none
module ucta_sync
  import ucta_pkg::*;
(
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   rst_n,
  // Pad levels
  ucta_sync_if.sync   sif
);
  logic [3:0] s1;
  logic [3:0] s2;
  logic [3:0] s3;
  logic [3:0] next_level;
  logic [3:0] next_rise;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_bit
      // A change counts once stages two and three agree
      always_comb begin
        next_level[g] = (s2[g] == s3[g]) ? s3[g] : sif.level[g];
        next_rise[g]  = next_level[g] & ~sif.level[g];
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1        <= 4'h0;
      s2        <= 4'h0;
      s3        <= 4'h0;
      sif.level <= 4'h0;
      sif.rise  <= 4'h0;
    end else begin
      s1        <= sif.raw;
      s2        <= s1;
      s3        <= s2;
      sif.level <= next_level;
      sif.rise  <= next_rise;
    end
  end
endmodule : ucta_sync
`default_nettype wire

// ---- ucta_top.sv ----
// Test mode entry and pad to user circuit access for the CPU macro
// What this block does
// - Test select high blocks system clock
// - One cfg0 rise enters user test mode
// - Address and read strobe pass to user
// - Direction select: one reads out, zero writes
// - Low byte write strobe forwarded in mode
// - High byte write strobe forwarded in mode
// - Write direction: pads become user write data
// - Read direction: user data driven onto pads
// - Test clock drives all five user clocks
// - Four direction rises enter DC/AC mode
`timescale 1ns/1ps
`default_nettype none
module ucta_top
  import ucta_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  // Entry pads
  input  wire logic                   pad_reset_n,
  input  wire logic                   pad_test_sel,
  input  wire logic                   pad_cfg0,
  input  wire logic                   pad_dir_select,
  // Access pads
  input  wire logic [UCTA_ADDR_W-1:0] pad_addr,
  input  wire logic                   pad_read_n,
  input  wire logic                   pad_write_lo_n,
  input  wire logic                   pad_write_hi_n,
  input  wire logic                   pad_test_clock,
  input  wire logic [UCTA_DATA_W-1:0] pad_data_in,
  output logic      [UCTA_DATA_W-1:0] pad_data_out,
  output logic      [UCTA_DATA_W-1:0] pad_data_oe,
  // System clock gating
  output logic                        sys_clock_enable,
  // Mode flags
  output logic                        user_test_active,
  output logic                        dct_test_active,
  // User circuit side
  output logic      [UCTA_ADDR_W-1:0] user_addr,
  output logic                        user_read_n,
  output logic                        user_write_lo_n,
  output logic                        user_write_hi_n,
  output logic      [UCTA_DATA_W-1:0] user_write_data,
  input  wire logic [UCTA_DATA_W-1:0] user_read_data,
  output logic                        user_busctl_clk,
  output logic                        user_slow_osc_clk,
  output logic                        user_fast_osc_clk,
  output logic                        user_pll_clk,
  output logic                        user_periph_clk
);
  // Bit positions in the synchroniser bundle
  localparam int B_RST  = 0;
  localparam int B_TST  = 1;
  localparam int B_CFG0 = 2;
  localparam int B_DIR  = 3;

  ucta_sync_if sif ();
  assign sif.raw = {pad_dir_select, pad_cfg0, pad_test_sel, pad_reset_n};

  ucta_sync u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .sif   (sif)
  );

  logic rst_lvl;
  logic tst_lvl;
  assign rst_lvl = sif.level[B_RST];
  assign tst_lvl = sif.level[B_TST];

  ucta_state_t           state;
  ucta_state_t           next_state;
  logic [UCTA_CNT_W-1:0] cnt;
  logic [UCTA_CNT_W-1:0] next_cnt;
  logic [UCTA_CNT_W-1:0] dir_cnt;
  logic [UCTA_CNT_W-1:0] next_dir_cnt;

  // Entry sequencer
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_dir_cnt = dir_cnt;
    case (state)
      UCTA_ST_NORMAL: begin
        if (!rst_lvl && !tst_lvl) begin
          next_state = UCTA_ST_SETTLE;
          next_cnt   = UCTA_CNT_ZERO;
        end
      end
      UCTA_ST_SETTLE: begin
        if (rst_lvl) begin
          next_state = UCTA_ST_NORMAL;
        end else if (tst_lvl) begin
          // Early test select drops back to normal: the macro is not yet settled
          next_state   = (cnt >= UCTA_SETTLE_CNT) ? UCTA_ST_ARMED : UCTA_ST_NORMAL;
          next_dir_cnt = UCTA_CNT_ZERO;
        end else if (cnt < UCTA_SETTLE_CNT) begin
          next_cnt = cnt + UCTA_CNT_ONE;
        end
      end
      UCTA_ST_ARMED: begin
        if (!tst_lvl) begin
          next_state = UCTA_ST_NORMAL;
        end else if (!rst_lvl) begin
          // single cfg0 rise selects user mode
          if (sif.rise[B_CFG0] && dir_cnt == UCTA_CNT_ZERO) begin
            next_state = UCTA_ST_USER;
          end else if (sif.rise[B_DIR] && dir_cnt < UCTA_DCT_CNT) begin
            next_dir_cnt = dir_cnt + UCTA_CNT_ONE;
          end
        end else begin
          next_state = (dir_cnt == UCTA_DCT_CNT) ? UCTA_ST_DCT : UCTA_ST_NORMAL;
        end
      end
      UCTA_ST_USER, UCTA_ST_DCT: begin
        // leave only on reset with test low
        if (!rst_lvl && !tst_lvl) begin
          next_state = UCTA_ST_SETTLE;
          next_cnt   = UCTA_CNT_ZERO;
        end
      end
      default: begin
        next_state = UCTA_ST_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state   <= UCTA_ST_NORMAL;
      cnt     <= UCTA_CNT_ZERO;
      dir_cnt <= UCTA_CNT_ZERO;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      dir_cnt <= next_dir_cnt;
    end
  end

  // Registered outputs
  logic                   in_user;
  logic                   next_clk_en;
  logic [UCTA_DATA_W-1:0] next_data_out;
  logic [UCTA_DATA_W-1:0] next_data_oe;
  logic [UCTA_DATA_W-1:0] next_wdata;
  logic [UCTA_ADDR_W-1:0] next_addr;
  logic                   next_rd_n;
  logic                   next_wl_n;
  logic                   next_wh_n;
  logic                   next_tclk;

  always_comb begin
    in_user = (next_state == UCTA_ST_USER);
    // block system clock once test select is high
    next_clk_en = !tst_lvl && (next_state == UCTA_ST_NORMAL || next_state == UCTA_ST_SETTLE);
    // address and read strobe pass through
    next_addr = in_user ? pad_addr : '0;
    next_rd_n = in_user ? pad_read_n : 1'b1;
    next_wl_n = in_user ? pad_write_lo_n : 1'b1;
    next_wh_n = in_user ? pad_write_hi_n : 1'b1;
    // direction select steers the data pads
    if (in_user && pad_dir_select == UCTA_DIR_READ) begin
      next_data_oe  = '1;
      next_data_out = user_read_data;
      next_wdata    = user_write_data;
    end else begin
      next_data_oe  = '0;
      next_data_out = '0;
      next_wdata    = in_user ? pad_data_in : '0;
    end
    // test clock feeds all user clocks
    next_tclk = in_user & pad_test_clock;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sys_clock_enable  <= 1'b1;
      user_test_active  <= 1'b0;
      dct_test_active   <= 1'b0;
      user_addr         <= '0;
      user_read_n       <= 1'b1;
      user_write_lo_n   <= 1'b1;
      user_write_hi_n   <= 1'b1;
      user_write_data   <= '0;
      pad_data_out      <= '0;
      pad_data_oe       <= '0;
      user_busctl_clk   <= 1'b0;
      user_slow_osc_clk <= 1'b0;
      user_fast_osc_clk <= 1'b0;
      user_pll_clk      <= 1'b0;
      user_periph_clk   <= 1'b0;
    end else begin
      sys_clock_enable  <= next_clk_en;
      user_test_active  <= in_user;
      dct_test_active   <= (next_state == UCTA_ST_DCT);
      user_addr         <= next_addr;
      user_read_n       <= next_rd_n;
      user_write_lo_n   <= next_wl_n;
      user_write_hi_n   <= next_wh_n;
      user_write_data   <= next_wdata;
      pad_data_out      <= next_data_out;
      pad_data_oe       <= next_data_oe;
      // user logic clocks come from this path only
      user_busctl_clk   <= next_tclk;
      user_slow_osc_clk <= next_tclk;
      user_fast_osc_clk <= next_tclk;
      user_pll_clk      <= next_tclk;
      user_periph_clk   <= next_tclk;
    end
  end
endmodule : ucta_top
`default_nettype wire

// ---- ucta_top_monitor.sv ----
// Checker for mode flags and pad pass-through timing
`timescale 1ns/1ps
`default_nettype none
module ucta_top_monitor
  import ucta_pkg::*;
(
  // Clock and reset
  input wire logic                   clock,
  input wire logic                   rst_n,
  // Pads
  input wire logic                   pad_test_sel,
  input wire logic                   pad_dir_select,
  input wire logic [UCTA_ADDR_W-1:0] pad_addr,
  input wire logic                   pad_read_n,
  input wire logic                   pad_write_lo_n,
  input wire logic                   pad_write_hi_n,
  input wire logic                   pad_test_clock,
  input wire logic [UCTA_DATA_W-1:0] pad_data_in,
  input wire logic [UCTA_DATA_W-1:0] pad_data_out,
  input wire logic [UCTA_DATA_W-1:0] pad_data_oe,
  // Flags
  input wire logic                   sys_clock_enable,
  input wire logic                   user_test_active,
  input wire logic                   dct_test_active,
  // User side
  input wire logic [UCTA_ADDR_W-1:0] user_addr,
  input wire logic                   user_read_n,
  input wire logic                   user_write_lo_n,
  input wire logic                   user_write_hi_n,
  input wire logic [UCTA_DATA_W-1:0] user_write_data,
  input wire logic [UCTA_DATA_W-1:0] user_read_data,
  input wire logic                   user_busctl_clk,
  input wire logic                   user_slow_osc_clk,
  input wire logic                   user_fast_osc_clk,
  input wire logic                   user_pll_clk,
  input wire logic                   user_periph_clk
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Mode held two cycles, so the pass-through registers saw it too
  logic was_user;
  logic in_mode;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) was_user <= 1'b0;
    else was_user <= user_test_active;
  end
  assign in_mode = user_test_active && was_user;
  property p_clk_off; user_test_active || dct_test_active |-> !sys_clock_enable; endproperty
  a_clk_off: assert property (p_clk_off) else $error("system clock enabled in test mode");
  property p_addr; in_mode |-> user_addr == $past(pad_addr) && user_read_n == $past(pad_read_n); endproperty
  a_addr: assert property (p_addr) else $error("address or read strobe not forwarded");
  property p_dir; in_mode |-> pad_data_oe == {UCTA_DATA_W{$past(pad_dir_select)}}; endproperty
  a_dir: assert property (p_dir) else $error("data enable does not follow direction");
  property p_wlo; in_mode |-> user_write_lo_n == $past(pad_write_lo_n); endproperty
  a_wlo: assert property (p_wlo) else $error("low write strobe not forwarded");
  property p_whi; in_mode |-> user_write_hi_n == $past(pad_write_hi_n); endproperty
  a_whi: assert property (p_whi) else $error("high write strobe not forwarded");
  property p_wr; in_mode && !$past(pad_dir_select) |-> user_write_data == $past(pad_data_in); endproperty
  a_wr: assert property (p_wr) else $error("write data not forwarded");
  property p_rd; in_mode && $past(pad_dir_select) |-> pad_data_out == $past(user_read_data); endproperty
  a_rd: assert property (p_rd) else $error("read data not driven out");
  property p_uclk;
    in_mode |-> {user_busctl_clk, user_slow_osc_clk, user_fast_osc_clk, user_pll_clk, user_periph_clk}
                == {5{$past(pad_test_clock)}};
  endproperty
  a_uclk: assert property (p_uclk) else $error("user clocks do not follow test clock");
  property p_one; !(user_test_active && dct_test_active); endproperty
  a_one: assert property (p_one) else $error("both test modes active");
  property p_hold; user_test_active && pad_test_sel |=> user_test_active; endproperty
  a_hold: assert property (p_hold) else $error("user mode dropped with test select high");
  c_user: cover property ($rose(user_test_active));
  c_dct: cover property ($rose(dct_test_active));
  c_read: cover property (in_mode && pad_dir_select);
endmodule : ucta_top_monitor
bind ucta_top ucta_top_monitor u_ucta_top_monitor (.*);
`default_nettype wire

// ---- ucta_tester.sv ----
// Tester model driving the entry pads
`timescale 1ns/1ps
`default_nettype none
module ucta_tester (
  // Clock
  input  wire logic clock,
  // Entry pads
  output var logic  pad_reset_n,
  output var logic  pad_test_sel,
  output var logic  pad_cfg0,
  output var logic  pad_dir_select
);
  initial begin
    pad_reset_n = 1'b0;
    pad_test_sel = 1'b0;
    pad_cfg0 = 1'b0;
    pad_dir_select = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask : hold
  task automatic enter(input logic dct);
    @(posedge clock);
    pad_reset_n <= 1'b0;
    pad_test_sel <= 1'b0;
    // Mode pins start low, else a stale level eats a rise
    pad_cfg0 <= 1'b0;
    pad_dir_select <= 1'b0;
    hold(8);
    pad_test_sel <= 1'b1;
    hold(8);
    repeat (dct ? 4 : 1) begin
      if (dct) pad_dir_select <= 1'b1;
      else pad_cfg0 <= 1'b1;
      hold(4);
      pad_dir_select <= 1'b0;
      pad_cfg0 <= 1'b0;
      hold(4);
    end
    pad_reset_n <= 1'b1;
    hold(12);
  endtask : enter
  task automatic leave;
    @(posedge clock);
    pad_reset_n <= 1'b0;
    pad_test_sel <= 1'b0;
    hold(12);
  endtask : leave
  // Test select raised before the settle count ends
  task automatic enter_early;
    @(posedge clock);
    pad_reset_n <= 1'b1;
    hold(8);
    pad_reset_n <= 1'b0;
    hold(2);
    pad_test_sel <= 1'b1;
    hold(8);
    pad_cfg0 <= 1'b1;
    hold(4);
    pad_cfg0 <= 1'b0;
    hold(8);
  endtask : enter_early
  // Data direction in the mode: one reads, zero writes
  task automatic steer(input logic rd);
    pad_dir_select <= rd;
  endtask : steer
endmodule : ucta_tester
`default_nettype wire

// ---- ucta_top_test.sv ----
// Self-checking bench for the test access block
`timescale 1ns/1ps
`default_nettype none
module ucta_top_test;
  import ucta_pkg::*;
  logic                   clock, rst_n, pad_reset_n, pad_test_sel, pad_cfg0, pad_dir_select;
  logic [UCTA_ADDR_W-1:0] pad_addr, user_addr;
  logic [UCTA_DATA_W-1:0] pad_data_in, pad_data_out, pad_data_oe, user_write_data, user_read_data;
  logic                   pad_read_n, pad_write_lo_n, pad_write_hi_n, pad_test_clock, sys_clock_enable;
  logic                   user_test_active, dct_test_active, user_read_n, user_write_lo_n, user_write_hi_n;
  logic                   user_busctl_clk, user_slow_osc_clk, user_fast_osc_clk, user_pll_clk, user_periph_clk;
  int                     fail_count = 0;
  int                     num_checks = 0;
  ucta_top u_ucta_top (.*);
  ucta_tester u_ucta_tester (.*);
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic t_user;
    check("clock enable", 1, sys_clock_enable);
    u_ucta_tester.enter(1'b0);
    #1;
    check("user flag", 1, user_test_active);
    check("clock enable", 0, sys_clock_enable);
    @(posedge clock);
    pad_test_clock <= 1'b1;
    pad_addr <= 18'h2a5c3;
    pad_data_in <= 16'hc35a;
    pad_write_lo_n <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check("address", 18'h2a5c3, user_addr);
    check("write data", 16'hc35a, user_write_data);
    check("low strobe", 0, user_write_lo_n);
    check("data enable", 0, pad_data_oe);
    check("user clocks", 5'h1f, {user_busctl_clk, user_slow_osc_clk, user_fast_osc_clk, user_pll_clk,
                                 user_periph_clk});
    @(posedge clock);
    u_ucta_tester.steer(1'b1);
    pad_test_clock <= 1'b0;
    pad_read_n <= 1'b0;
    pad_write_lo_n <= 1'b1;
    pad_write_hi_n <= 1'b0;
    pad_data_in <= 16'h0ff0;
    user_read_data <= 16'h5aa5;
    repeat (3) @(posedge clock);
    #1;
    check("data enable", 16'hffff, pad_data_oe);
    check("read data out", 16'h5aa5, pad_data_out);
    check("read strobe", 0, user_read_n);
    check("high strobe", 0, user_write_hi_n);
    check("user clocks", 5'h00, {user_busctl_clk, user_slow_osc_clk, user_fast_osc_clk, user_pll_clk,
                                 user_periph_clk});
    check("write data held", 16'hc35a, user_write_data);
    u_ucta_tester.leave();
    #1;
    check("user flag", 0, user_test_active);
  endtask : t_user
  task automatic t_dct;
    u_ucta_tester.enter(1'b1);
    #1;
    check("dct flag", 1, dct_test_active);
    check("user flag", 0, user_test_active);
    check("clock enable", 0, sys_clock_enable);
    check("read strobe", 1, user_read_n);
    u_ucta_tester.leave();
    #1;
    check("dct flag", 0, dct_test_active);
  endtask : t_dct
  task automatic t_early;
    u_ucta_tester.enter_early();
    #1;
    check("user flag", 0, user_test_active);
    check("dct flag", 0, dct_test_active);
    check("clock enable", 0, sys_clock_enable);
    u_ucta_tester.leave();
    #1;
    check("clock enable", 1, sys_clock_enable);
  endtask : t_early
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (3000) @(posedge clock);
    fail_count++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    pad_addr = '0;
    pad_data_in = '0;
    user_read_data = '0;
    pad_read_n = 1'b1;
    pad_write_lo_n = 1'b1;
    pad_write_hi_n = 1'b1;
    pad_test_clock = 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_user();
    t_dct();
    t_early();
    final_report();
  end
endmodule : ucta_top_test
`default_nettype wire
